// [design/pci_ctrl.sv]
// Design decisions made here: the APB interface to the registers and the register addresses.
module pci_ctrl import pci_pkg::*; #(
	parameter logic [15:0] RETRY_CYC = RETRY_CYC_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic supply_ok,
	input wire logic run_pin_in,
	output logic run_pin_out,
	output logic run_pin_oe,
	input wire logic fault_pin_in,
	output logic fault_pin_out,
	output logic fault_pin_oe,
	output logic alert_n,
	input wire logic write_protect,
	input wire logic peak_current_comparator,
	input wire logic chan_clk_edge,
	output logic high_side_gate_drive,
	output logic low_side_gate_drive,
	input wire logic [3:0] bus_addr_strap,
	input wire logic bus_addr_strap_open,
	input wire logic [3:0] strap_resistor_setting,
	input wire logic strap_resistor_fitted,
	input wire logic signed [11:0] die_temp,
	input wire logic [FAULT_N-1:0] fault_raw,
	input wire pci_telem_s telem,
	output logic [11:0] dac_code,
	output logic [6:0] bus_addr,
	output pci_cm_req_s cm_req,
	input wire logic [15:0] cm_rdata,
	input wire logic cm_rvalid
);

	pci_regs_s q;
	pci_regs_s d;
	logic [PIN_W-1:0] pins;
	logic [FAULT_N-1:0] act;
	logic [FAULT_N-1:0] clr;
	logic [FAULT_N-1:0] cml_evt;
	logic [31:0] rd_val;
	logic hit;
	logic wp_block;
	logic user_w;
	logic fault_drive;
	logic ext_sd;
	logic run_ok;
	logic [15:0] telem_w [TELEM_N];

	// 0.1 mV resolution is not needed; 16-bit fixed point keeps one multiplier
	function automatic logic [11:0] dac_of(input logic [15:0] mv, input logic half);
		logic [32:0] p;
		p = mv * (half ? DAC_K_HALF : DAC_K_NORM);
		return (p[32:16] > {5'h00, DAC_MAX}) ? DAC_MAX : p[27:16];
	endfunction

	assign pins = {strap_resistor_setting, strap_resistor_fitted, bus_addr_strap,
		bus_addr_strap_open, peak_current_comparator, write_protect, fault_pin_in,
		run_pin_in, supply_ok};
	assign telem_w[0] = telem.temp_int;
	assign telem_w[1] = telem.temp_ext;
	assign telem_w[2] = telem.iout_avg;
	assign telem_w[3] = telem.duty;
	assign telem_w[4] = telem.vout;
	assign telem_w[5] = telem.vin;
	assign telem_w[6] = telem.iin;

	assign act = fault_raw & ~q.mask;
	// our own pull-down is seen on the pin a few cycles late, so external
	// shutdown is only honoured while we are not driving
	assign fault_drive = (q.st == ST_RUN) && q.ctrl[CTRL_FPROP] && (|q.fstat);
	assign ext_sd = q.ctrl[CTRL_FEXT] && !q.flt[P_FPIN] && !fault_drive;
	assign run_ok = (q.st == ST_RUN) && q.flt[P_RUN] && q.ctrl[CTRL_ON] && !q.latched_off
		&& (q.retry == 16'h0000) && !(|act) && !ext_sd;
	assign wp_block = q.flt[P_WP] && (paddr != OFF_FSTAT);

	always_comb begin
		hit = 1'b1;
		rd_val = 32'h0000_0000;
		case (paddr)
			OFF_STATUS: rd_val = 32'({q.log_ptr, q.tblock, q.latched_off, q.bus_addr, q.st});
			OFF_VOUT: rd_val = 32'(q.vout);
			OFF_CTRL: rd_val = 32'(q.ctrl);
			OFF_MASK: rd_val = 32'(q.mask);
			OFF_LATCH: rd_val = 32'(q.latch);
			OFF_FSTAT: rd_val = 32'(q.fstat);
			OFF_FLIVE: rd_val = 32'(fault_raw);
			OFF_CMW: rd_val = 32'h0000_0000;
			OFF_DAC: rd_val = 32'(q.dac);
			OFF_GLOB: rd_val = 32'(q.glob);
			default: begin
				if (paddr >= OFF_TELEM && paddr < OFF_TELEM + 8'(4 * TELEM_N)
					&& paddr[1:0] == 2'h0) begin
					rd_val = 32'(telem_w[3'(6'(paddr - OFF_TELEM) >> 2)]);
				end else begin
					hit = 1'b0;
				end
			end
		endcase
	end

	always_comb begin
		d = q;
		clr = '0;
		cml_evt = '0;
		user_w = 1'b0;
		d.s1 = pins;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.flt = (q.s3 & ~(q.s2 ^ q.s3)) | (q.flt & (q.s2 ^ q.s3));
		d.cm.rd = 1'b0;
		d.cm.wr = 1'b0;
		d.cm_is_log = 1'b0;

		if (die_temp > TEMP_BLOCK_C) begin
			d.tblock = 1'b1;
		end else if (die_temp < TEMP_CLEAR_C) begin
			d.tblock = 1'b0;
		end

		case (q.st)
			ST_WAIT: begin
				if (q.flt[P_SUP]) begin
					d.st = ST_LOAD;
					d.ld_idx = 3'h0;
					d.cm.rd = 1'b1;
					d.cm.addr = 4'h0;
				end
			end
			ST_LOAD: begin
				if (cm_rvalid) begin
					case (q.ld_idx)
						CMW_GLOBAL: d.glob = cm_rdata;
						CMW_VOUT: d.vout = cm_rdata;
						CMW_ADDR: d.addr_word = cm_rdata;
						CMW_MASK: d.mask = cm_rdata[FAULT_N-1:0];
						CMW_LATCH: d.latch = cm_rdata[FAULT_N-1:0];
						default: ;
					endcase
					if ({1'b0, q.ld_idx} == CM_CFG_WORDS - 4'h1) begin
						d.st = ST_APPLY;
					end else begin
						d.ld_idx = q.ld_idx + 3'h1;
						d.cm.rd = 1'b1;
						d.cm.addr = {1'b0, q.ld_idx + 3'h1};
					end
				end
			end
			ST_APPLY: begin
				if (q.flt[P_VFIT] && !q.glob[GLOB_IGN_STRAP]) begin
					d.vout = 16'(STRAP_VOUT_BASE + q.flt[P_VSTR+:4] * STRAP_VOUT_STEP);
				end
				// open strap falls back to the stored low bits
				d.bus_addr = {q.addr_word[6:4],
					q.flt[P_AOPEN] ? q.addr_word[3:0] : q.flt[P_ASTR+:4]};
				d.st = ST_RUN;
			end
			ST_RUN: ;
			default: d.st = ST_WAIT;
		endcase
		if (!q.flt[P_SUP]) begin
			d.st = ST_WAIT;
		end

		// two-cycle access keeps read data registered
		if (psel && penable && !q.apb_rdy) begin
			d.apb_rdy = 1'b1;
			d.prdata = rd_val;
			d.pslverr = !hit || (pwrite && wp_block);
		end
		if (psel && penable && q.apb_rdy) begin
			d.apb_rdy = 1'b0;
			if (pwrite && !q.pslverr) begin
				case (paddr)
					OFF_VOUT: d.vout = pwdata[15:0];
					OFF_CTRL: d.ctrl = pwdata[CTRL_W-1:0];
					OFF_MASK: d.mask = pwdata[FAULT_N-1:0];
					OFF_LATCH: d.latch = pwdata[FAULT_N-1:0];
					OFF_FSTAT: clr = pwdata[FAULT_N-1:0];
					OFF_GLOB: d.glob = pwdata[15:0];
					OFF_CMW: begin
						if (q.st == ST_RUN && !q.tblock && pwdata[19:16] < CM_CFG_WORDS) begin
							d.cm.wr = 1'b1;
							d.cm.addr = pwdata[19:16];
							d.cm.wdata = pwdata[15:0];
							user_w = 1'b1;
						end else begin
							cml_evt[FLT_CML] = 1'b1;
						end
					end
					default: ;
				endcase
			end
		end

		// log entries only ever land above the configuration words
		if (q.log_pend && !q.tblock && !user_w && q.st == ST_RUN) begin
			d.cm.wr = 1'b1;
			d.cm.addr = LOG_BASE + {1'b0, q.log_ptr};
			d.cm.wdata = 16'(q.log_data);
			d.cm_is_log = 1'b1;
			d.log_pend = 1'b0;
			d.log_ptr = q.log_ptr + 3'h1;
		end

		d.dac = dac_of(q.vout, q.ctrl[CTRL_RANGE]);

		// set wins over the clear in the same cycle
		d.fstat = (q.fstat & ~clr) | act | (cml_evt & ~q.mask);
		if (|(d.fstat & ~q.fstat)) begin
			d.log_pend = 1'b1;
			d.log_data = d.fstat;
		end
		if (!q.flt[P_RUN] || !q.ctrl[CTRL_ON]) begin
			d.latched_off = 1'b0;
		end
		if (|(act & q.latch)) begin
			d.latched_off = 1'b1;
		end
		if (|(act & ~q.latch)) begin
			d.retry = RETRY_CYC;
		end else if (q.retry != 16'h0000) begin
			d.retry = q.retry - 16'h0001;
		end

		// leaving run drops the gates on the same edge, not one cycle later
		if (!run_ok || d.st != ST_RUN) begin
			d.hs = 1'b0;
			d.ls = 1'b0;
			d.hs_pend = 1'b0;
		end else begin
			// one idle cycle between low-side off and high-side on
			if (q.hs_pend) begin
				d.hs = 1'b1;
				d.hs_pend = 1'b0;
			end
			if (q.hs && q.flt[P_PCMP]) begin
				d.hs = 1'b0;
				d.ls = 1'b1;
			end
			if (chan_clk_edge) begin
				d.ls = 1'b0;
				d.hs_pend = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.st <= ST_WAIT;
			q.ctrl <= CTRL_RST;
			q.mask <= MASK_RST;
			q.latch <= LATCH_RST;
		end else begin
			q <= d;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.apb_rdy;
	assign pslverr = q.apb_rdy && q.pslverr;
	assign high_side_gate_drive = q.hs;
	assign low_side_gate_drive = q.ls;
	assign run_pin_out = 1'b0;
	assign run_pin_oe = (q.st == ST_RUN);
	assign fault_pin_out = 1'b0;
	assign fault_pin_oe = !fault_drive;
	assign alert_n = !(|q.fstat);
	assign dac_code = q.dac;
	assign bus_addr = q.bus_addr;
	assign cm_req = q.cm;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	init_hold_a: assert property ((q.st != ST_RUN) |-> !high_side_gate_drive
		&& !low_side_gate_drive && !run_pin_oe && fault_pin_oe)
		else $error("gates or pins active while loading");
	gate_after_load_a: assert property ((high_side_gate_drive || low_side_gate_drive)
		|-> q.st == ST_RUN && $past(q.flt[P_RUN]))
		else $error("gate switched before load completed");
	hs_set_a: assert property ($rose(high_side_gate_drive) |-> $past(q.hs_pend)
		&& !low_side_gate_drive)
		else $error("high side set without clock edge");
	hs_reset_a: assert property ((q.hs && q.flt[P_PCMP] && run_ok)
		|=> !high_side_gate_drive && low_side_gate_drive)
		else $error("peak trip did not hand over to low side");
	ls_hold_a: assert property ((q.ls && run_ok && !chan_clk_edge) |=> low_side_gate_drive)
		else $error("low side dropped before cycle end");
	dac_norm_a: assert property ((q.vout == 16'h157c && !q.ctrl[CTRL_RANGE])
		|=> dac_code == 12'hfa0)
		else $error("reference code wrong in normal range");
	dac_half_a: assert property ((q.vout == 16'h0abe && q.ctrl[CTRL_RANGE])
		|=> dac_code == 12'hfa0)
		else $error("reference code wrong in low range");
	dac_full_a: assert property ((q.vout >= 16'h1600 && !q.ctrl[CTRL_RANGE])
		|=> dac_code == 12'hfff)
		else $error("reference code not clamped at full scale");
	temp_block_a: assert property ((die_temp > 12'sh082) |=> q.tblock ##1 !cm_req.wr)
		else $error("memory write not blocked when hot");
	temp_hyst_a: assert property ((q.tblock && die_temp >= 12'sh07d) |=> q.tblock)
		else $error("write block released inside hysteresis");
	log_region_a: assert property (cm_req.wr |-> (q.cm_is_log == cm_req.addr[3]))
		else $error("write landed in the wrong memory region");
	load_start_a: assert property ((q.st == ST_LOAD && $past(q.st) == ST_WAIT)
		|-> $past(q.flt[P_SUP]))
		else $error("load began under supply lockout");
	addr_strap_a: assert property (($past(q.st) == ST_APPLY && !$past(q.flt[P_AOPEN]))
		|-> bus_addr == {$past(q.addr_word[6:4]), $past(q.flt[P_ASTR+:4])})
		else $error("bus address not built from strap and memory");
	strap_ign_a: assert property (($past(q.st) == ST_APPLY && !$past(psel)
		&& ($past(q.glob[GLOB_IGN_STRAP]) || !$past(q.flt[P_VFIT])))
		|-> q.vout == $past(q.vout))
		else $error("strap used while ignored or absent");
	fault_latch_a: assert property ((|(fault_raw & ~q.mask & q.latch))
		|=> q.latched_off ##1 !high_side_gate_drive)
		else $error("latched fault did not shut down");
	fault_report_a: assert property ((|(fault_raw & ~q.mask)) |=> !alert_n)
		else $error("unmasked fault not reported");
	wp_refuse_a: assert property ((psel && penable && !q.apb_rdy && pwrite
		&& q.flt[P_WP] && paddr != OFF_FSTAT) |=> pslverr)
		else $error("write accepted under write protect");

endmodule

// [design/pci_pkg.sv]
package pci_pkg;
// Operation
// - the management bus is never clocked faster than 400 kHz by its host
// - channel clock edge sets the high-side latch, peak comparator trip clears it
// - low-side gate follows high-side off and holds until the cycle ends
// - a 12-bit reference code spans zero to 1.024 V full scale
// - code scaling assumes output is 5.5x reference, 2.75x when range is one
// - a new output set-point is accepted any time and applied well under 10 ms
// - every fault is maskable and shuts down either with retry or latched off; a refused memory write only sets its status bit
// - each output, input, current, temperature and memory fault has its own status bit
// - the bidirectional fault pin is configurable and a separate alert output exists
// - memory writes are blocked above 130 degC until below 125 degC
// - fault logging writes only the fault log region of memory
// - configuration loading starts only after the supply lockout releases
// - straps are sampled and memory words copied into working values at start-up
// - while loading, both gates and the enable pin stay low, fault pin floats
// - straps override only output voltage and address; the rest comes from memory
// - straps absent or global config bit 6 set means memory values only; bit 6 here drops only the voltage strap, not the address strap
// - the address strap is always honoured unless detected open
// - bus address joins memory upper bits with strap lower bits
// - telemetry words and latched and live fault status are readable
// - the address strap sets exactly the four low address bits
// - write protect high refuses register and memory writes except status clears

localparam int CLK_HZ = 100_000_000;
localparam int FAULT_N = 9;
localparam int CTRL_W = 4;
localparam int CTRL_RANGE = 0;
localparam int CTRL_FPROP = 1;
localparam int CTRL_FEXT = 2;
localparam int CTRL_ON = 3;
localparam logic [CTRL_W-1:0] CTRL_RST = 4'ha;
localparam logic [FAULT_N-1:0] MASK_RST = 9'h000;
localparam logic [FAULT_N-1:0] LATCH_RST = 9'h000;
localparam int GLOB_IGN_STRAP = 6;
localparam int FLT_CML = 8;

localparam logic [7:0] OFF_STATUS = 8'h00;
localparam logic [7:0] OFF_VOUT = 8'h04;
localparam logic [7:0] OFF_CTRL = 8'h08;
localparam logic [7:0] OFF_MASK = 8'h0c;
localparam logic [7:0] OFF_LATCH = 8'h10;
localparam logic [7:0] OFF_FSTAT = 8'h14;
localparam logic [7:0] OFF_FLIVE = 8'h18;
localparam logic [7:0] OFF_CMW = 8'h1c;
localparam logic [7:0] OFF_DAC = 8'h20;
localparam logic [7:0] OFF_GLOB = 8'h24;
localparam logic [7:0] OFF_TELEM = 8'h28;
localparam int TELEM_N = 7;

localparam logic [2:0] CMW_GLOBAL = 3'h0;
localparam logic [2:0] CMW_VOUT = 3'h1;
localparam logic [2:0] CMW_ADDR = 3'h2;
localparam logic [2:0] CMW_MASK = 3'h3;
localparam logic [2:0] CMW_LATCH = 3'h4;
localparam logic [3:0] CM_CFG_WORDS = 4'h5;
localparam logic [3:0] LOG_BASE = 4'h8;

localparam logic [15:0] STRAP_VOUT_BASE = 16'h01f4;
localparam logic [15:0] STRAP_VOUT_STEP = 16'h0190;
localparam logic [16:0] DAC_K_NORM = 17'hba2f;
localparam logic [16:0] DAC_K_HALF = 17'h1745e;
localparam logic [11:0] DAC_MAX = 12'hfff;
localparam logic signed [11:0] TEMP_BLOCK_C = 12'sh082;
localparam logic signed [11:0] TEMP_CLEAR_C = 12'sh07d;
localparam logic [15:0] RETRY_CYC_DEF = 16'h03e8;

localparam int P_SUP = 0;
localparam int P_RUN = 1;
localparam int P_FPIN = 2;
localparam int P_WP = 3;
localparam int P_PCMP = 4;
localparam int P_AOPEN = 5;
localparam int P_ASTR = 6;
localparam int P_VFIT = 10;
localparam int P_VSTR = 11;
localparam int PIN_W = 15;

typedef enum logic [3:0] {
	ST_WAIT = 4'b0001,
	ST_LOAD = 4'b0010,
	ST_APPLY = 4'b0100,
	ST_RUN = 4'b1000
} pci_state_e;

typedef struct packed {
	logic [15:0] temp_int;
	logic [15:0] temp_ext;
	logic [15:0] iout_avg;
	logic [15:0] duty;
	logic [15:0] vout;
	logic [15:0] vin;
	logic [15:0] iin;
} pci_telem_s;

typedef struct packed {
	logic rd;
	logic wr;
	logic [3:0] addr;
	logic [15:0] wdata;
} pci_cm_req_s;

typedef struct packed {
	logic [PIN_W-1:0] s1;
	logic [PIN_W-1:0] s2;
	logic [PIN_W-1:0] s3;
	logic [PIN_W-1:0] flt;
	pci_state_e st;
	logic [2:0] ld_idx;
	logic [15:0] glob;
	logic [15:0] vout;
	logic [15:0] addr_word;
	logic [FAULT_N-1:0] mask;
	logic [FAULT_N-1:0] latch;
	logic [FAULT_N-1:0] fstat;
	logic [CTRL_W-1:0] ctrl;
	logic [6:0] bus_addr;
	logic [11:0] dac;
	logic latched_off;
	logic [15:0] retry;
	logic hs;
	logic ls;
	logic hs_pend;
	logic tblock;
	logic apb_rdy;
	logic pslverr;
	logic [31:0] prdata;
	pci_cm_req_s cm;
	logic cm_is_log;
	logic log_pend;
	logic [2:0] log_ptr;
	logic [FAULT_N-1:0] log_data;
} pci_regs_s;

endpackage

// [sim/pci_mem_model.sv]
module pci_mem_model import pci_pkg::*; (
	input wire logic clk,
	input wire pci_cm_req_s req,
	output logic [15:0] rdata,
	output logic rvalid
);
	timeunit 1ns;
	timeprecision 1ps;
	// answer delay in cycles; the bench raises it to exercise slow loads
	int lat = 1;
	int cnt = 0;
	int cfg_wr = 0;
	int log_wr = 0;
	logic [3:0] ra = 4'h0;
	logic [15:0] mem [16];
	initial begin
		rdata = 16'h0000;
		rvalid = 1'b0;
	end
	always @(posedge clk) begin
		rvalid <= 1'b0;
		// a released data bus must not look like a fresh word
		if (rvalid === 1'b1)
			rdata <= ~rdata;
		if (req.wr === 1'b1) begin
			mem[req.addr] <= req.wdata;
			if (req.addr < LOG_BASE)
				cfg_wr <= cfg_wr + 1;
			else
				log_wr <= log_wr + 1;
		end
		if (req.rd === 1'b1) begin
			ra <= req.addr;
			cnt <= lat;
		end else if (cnt == 1) begin
			rvalid <= 1'b1;
			rdata <= mem[ra];
			cnt <= 0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
endmodule

// [sim/tb.sv]
module tb import pci_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rdat;
	logic pready, pslverr, rerr;
	logic supply_ok = 1'b0;
	logic run_ext = 1'b1;
	logic wp = 1'b0;
	logic pcmp = 1'b0;
	logic cedge = 1'b0;
	logic aopen = 1'b0;
	logic vfit = 1'b1;
	logic fp_ext = 1'b1;
	logic [3:0] astrap = 4'h3;
	logic signed [11:0] temp = 12'sh028;
	logic [FAULT_N-1:0] fraw = '0;
	pci_telem_s telem = {16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555, 16'h6666, 16'h7777};
	logic run_out, run_oe, fp_out, fp_oe, alert_n, hs, ls, cmrv;
	logic [11:0] dac;
	logic [6:0] baddr;
	logic [15:0] cmrd;
	pci_cm_req_s cmreq;
	int bad_count = 0;
	int checks_done = 0;
	int cyc = 0;
	// outside party drives enable open-drain over a pull-up
	wire logic run_in = (run_oe ? 1'b1 : run_out) & run_ext;
	wire logic fp_in = (fp_oe ? 1'b1 : fp_out) & fp_ext;

	pci_ctrl #(.RETRY_CYC(16'h000a)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .supply_ok(supply_ok), .run_pin_in(run_in),
		.run_pin_out(run_out), .run_pin_oe(run_oe), .fault_pin_in(fp_in),
		.fault_pin_out(fp_out), .fault_pin_oe(fp_oe), .alert_n(alert_n), .write_protect(wp),
		.peak_current_comparator(pcmp), .chan_clk_edge(cedge), .high_side_gate_drive(hs),
		.low_side_gate_drive(ls), .bus_addr_strap(astrap), .bus_addr_strap_open(aopen),
		.strap_resistor_setting(4'h3), .strap_resistor_fitted(vfit), .die_temp(temp),
		.fault_raw(fraw), .telem(telem), .dac_code(dac), .bus_addr(baddr), .cm_req(cmreq),
		.cm_rdata(cmrd), .cm_rvalid(cmrv));
	pci_mem_model u_mem (.clk(pclk), .req(cmreq), .rdata(cmrd), .rvalid(cmrv));

	always #5 pclk = ~pclk;

	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// run takes well under a thousand cycles; the 20000-cycle ceiling leaves ample margin
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			wrap_up;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// pready is looked at between edges, where it has settled
		do begin
			@(negedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask

	task automatic edge_pulse;
		cedge <= 1'b1;
		@(posedge pclk);
		cedge <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wait_hs(input logic v);
		for (int i = 0; i < 20 && hs !== v; i++)
			@(negedge pclk);
		chk(32'(hs), 32'(v));
		@(posedge pclk);
	endtask

	task automatic t_init(input logic [15:0] g, input logic o, input logic f, input int lat,
			input logic [15:0] ve, input logic [6:0] ae);
		u_mem.mem[0] = g;
		u_mem.mem[1] = 16'h03e8;
		u_mem.mem[2] = 16'h005a;
		u_mem.mem[3] = 16'h0000;
		u_mem.mem[4] = 16'h0000;
		u_mem.lat = lat;
		aopen <= o;
		vfit <= f;
		presetn <= 1'b0;
		supply_ok <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		edge_pulse;
		repeat (20) @(posedge pclk);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(32'(rdat[3:0]), 32'h1);
		chk(32'({hs, ls}), 32'h0);
		supply_ok <= 1'b1;
		repeat (6) @(posedge pclk);
		chk(32'({hs, ls, run_oe, fp_oe}), 32'h1);
		for (int i = 0; i < 60 && rdat[3:0] !== 4'h8; i++)
			apb(1'b0, OFF_STATUS, 32'h0);
		chk(32'(rdat[10:0]), 32'({ae, 4'h8}));
		chk(32'(baddr), 32'(ae));
		rd_chk(OFF_VOUT, 32'(ve));
		chk(32'(run_oe), 32'h1);
	endtask

	task automatic t_dac;
		apb(1'b1, OFF_VOUT, 32'd5500);
		rd_chk(OFF_DAC, 32'hfa0);
		apb(1'b1, OFF_CTRL, 32'hb);
		rd_chk(OFF_DAC, 32'hfff);
		apb(1'b1, OFF_VOUT, 32'd2750);
		rd_chk(OFF_DAC, 32'hfa0);
		apb(1'b1, OFF_CTRL, 32'ha);
		apb(1'b1, OFF_VOUT, 32'd6000);
		rd_chk(OFF_DAC, 32'hfff);
		apb(1'b1, OFF_VOUT, 32'd0);
		rd_chk(OFF_DAC, 32'h0);
	endtask

	task automatic t_gate;
		edge_pulse;
		wait_hs(1'b1);
		chk(32'(ls), 32'h0);
		pcmp <= 1'b1;
		wait_hs(1'b0);
		chk(32'(ls), 32'h1);
		pcmp <= 1'b0;
		repeat (10) @(posedge pclk);
		chk(32'(ls), 32'h1);
		edge_pulse;
		wait_hs(1'b1);
		chk(32'(ls), 32'h0);
		apb(1'b1, OFF_CTRL, 32'he);
		fp_ext <= 1'b0;
		wait_hs(1'b0);
		fp_ext <= 1'b1;
		apb(1'b1, OFF_CTRL, 32'ha);
	endtask

	task automatic t_fault;
		for (int i = 0; i < FAULT_N; i++) begin
			fraw <= FAULT_N'(1 << i);
			@(posedge pclk);
			rd_chk(OFF_FLIVE, 32'(1 << i));
		end
		fraw <= '0;
		chk(32'({hs, ls, alert_n, fp_oe}), 32'h0);
		rd_chk(OFF_FSTAT, 32'h1ff);
		apb(1'b1, OFF_FSTAT, 32'h1ff);
		chk(32'({alert_n, fp_oe}), 32'h3);
		repeat (12) @(posedge pclk);
		edge_pulse;
		wait_hs(1'b1);
		apb(1'b1, OFF_LATCH, 32'h1);
		fraw <= 9'h001;
		wait_hs(1'b0);
		fraw <= '0;
		repeat (30) @(posedge pclk);
		edge_pulse;
		repeat (5) @(posedge pclk);
		chk(32'(hs), 32'h0);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(32'(rdat[11]), 32'h1);
		apb(1'b1, OFF_CTRL, 32'h2);
		apb(1'b1, OFF_CTRL, 32'ha);
		apb(1'b1, OFF_LATCH, 32'h0);
		apb(1'b1, OFF_MASK, 32'h1);
		apb(1'b1, OFF_FSTAT, 32'h1ff);
		edge_pulse;
		wait_hs(1'b1);
		fraw <= 9'h001;
		repeat (10) @(posedge pclk);
		chk(32'(hs), 32'h1);
		fraw <= '0;
		apb(1'b1, OFF_MASK, 32'h0);
	endtask

	task automatic t_temp;
		int c0;
		c0 = u_mem.cfg_wr;
		temp <= 12'sh082;
		@(posedge pclk);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(32'(rdat[12]), 32'h0);
		temp <= 12'sh083;
		@(posedge pclk);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(32'(rdat[12]), 32'h1);
		apb(1'b1, OFF_CMW, 32'h0001_0777);
		repeat (3) @(posedge pclk);
		chk(32'(u_mem.mem[1]), 32'h03e8);
		apb(1'b0, OFF_FSTAT, 32'h0);
		chk(32'(rdat[FLT_CML]), 32'h1);
		temp <= 12'sh07f;
		@(posedge pclk);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(32'(rdat[12]), 32'h1);
		temp <= 12'sh07c;
		@(posedge pclk);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(32'(rdat[12]), 32'h0);
		temp <= 12'sh028;
		apb(1'b1, OFF_CMW, 32'h0001_0777);
		repeat (3) @(posedge pclk);
		chk(32'(u_mem.mem[1]), 32'h0777);
		chk(32'(u_mem.cfg_wr), 32'(c0 + 1));
		chk(32'(u_mem.log_wr > 0), 32'h1);
	endtask

	task automatic t_wp;
		wp <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b1, OFF_VOUT, 32'd900);
		chk(32'(rerr), 32'h1);
		rd_chk(OFF_VOUT, 32'h0);
		apb(1'b1, OFF_FSTAT, 32'h1ff);
		chk(32'(rerr), 32'h0);
		rd_chk(OFF_FSTAT, 32'h0);
		wp <= 1'b0;
		repeat (4) @(posedge pclk);
		apb(1'b1, 8'h44, 32'h0);
		chk(32'(rerr), 32'h1);
		apb(1'b1, OFF_VOUT, 32'd900);
		rd_chk(OFF_VOUT, 32'd900);
		for (int i = 0; i < TELEM_N; i++)
			rd_chk(OFF_TELEM + 8'(4 * i), 32'(16'h1111 * (i + 1)));
	endtask

	initial begin
		t_init(16'h0000, 1'b0, 1'b1, 3, 16'h06a4, 7'h53);
		t_init(16'h0000, 1'b0, 1'b0, 1, 16'h03e8, 7'h53);
		t_init(16'h0040, 1'b1, 1'b1, 6, 16'h03e8, 7'h5a);
		t_dac;
		t_gate;
		t_fault;
		t_temp;
		t_wp;
		wrap_up;
	end
endmodule
